/* File: rtl/euart_pkg.sv */
// Purpose: Constants for the enhanced serial port with its own bit rate generator.
// Assumes: One clock domain at the CPU clock rate; register offsets are chosen locally.
// Notes: Offsets are word indices on a plain strobe port.
// What this block does
// R1: Shift-register mode moves data on the receive pin, clocks on transmit, 8 bits LSB first.
// R2: Shift-register mode runs at one sixteenth of the CPU clock, nothing else.
// R3: 8-bit mode frames are start low, eight data bits LSB first, stop high.
// R4: 8-bit mode reception stores the stop bit as received ninth bit.
// R5: 8-bit mode rate comes from Timer 1 overflow or the divisor generator.
// R6: Fixed 9-bit mode sends start, eight data, ninth bit from software, stop.
// R7: 9-bit modes store received ninth bit and drop the stop bit.
// R8: Fixed 9-bit mode runs at CPU clock over 16 or 32 by half-rate select.
// R9: Variable 9-bit mode equals fixed 9-bit mode but with the variable rate.
// R10: Divisor generator runs on the CPU clock, dividing by the two divisor bytes plus one.
// R11: Timer 1 overflow is halved again when half-rate select is clear.
// R12: Timer 2 overflow is never a rate source.
// R13: Framing error always in status; shown at control bit 7 when error view set.
// R14: Software sets the mode bits while error view is clear.
// R15: Eleven low bit times on the receive line report a break in status.
// R16: A detected break raises a device reset request when enabled.
// R17: Double buffering accepts the next byte while shifting; one stop bit between.
// R18: With double buffering clear the transmit flag rises at frame end; outside shift-register mode a byte written while shifting is buffered and sent next.
// R19: Software keeps double buffering off in shift-register mode.
// R20: With double buffering the transmit flag rises when the buffer empties.
// R21: The ninth bit is latched with the buffered byte; write it first.
// R22: Receiver finds the start edge and samples mid-bit at sixteen times the rate.
// R23: A low stop bit sets framing error until software clears it.
package euart_pkg;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_STAT = 3'h2;
  localparam logic [2:0] ADDR_PWR = 3'h3;
  localparam logic [2:0] ADDR_DIVL = 3'h4;
  localparam logic [2:0] ADDR_DIVH = 3'h5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam int OVERSAMPLE = 16;
  localparam int SHIFT_DIV = 16;
  localparam int BREAK_BITS = 11;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  // Control bits.
  localparam int C_SM0 = 7;
  localparam int C_SM1 = 6;
  localparam int C_REN = 4;
  localparam int C_TB8 = 3;
  localparam int C_RB8 = 2;
  localparam int C_TI = 1;
  localparam int C_RI = 0;
  // Status bits.
  localparam int S_DBM = 7;
  localparam int S_BRK_RST = 6;
  localparam int S_BRG_SEL = 5;
  localparam int S_BR = 3;
  localparam int S_FE = 2;
  // Power-control bits.
  localparam int P_HALF = 7;
  localparam int P_VIEW = 6;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } tx_state_t;
endpackage

/* File: rtl/euart.sv */
// Purpose: Enhanced serial port with fixed, Timer 1 and divisor generator rates.
// Assumes: Timer 1 overflow arrives as a one-cycle pulse on the CPU clock.
// Notes: Address detection and interrupts stay outside this block.
`timescale 1ns/1ps
module euart (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Rate source.
  input wire logic t1_ovf,
  // Serial pins; enables are low while driving.
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oen,
  output logic txd,
  // Reset request.
  output logic break_reset_req
);
  logic rx_s1_q, rx_s2_q;
  logic [7:0] ctrl_q, stat_q, pwr_q, div_lo_q, div_hi_q;
  logic [15:0] brg_cnt_q;
  logic brg_tick, t1_half_q, var_tick;
  logic [4:0] fix_cnt_q;
  logic tick_q;
  logic [1:0] mode;
  logic [7:0] txbuf_q, rxbuf_q;
  logic txbuf_full_q, tb8_buf_q;
  euart_pkg::tx_state_t tx_st_q;
  logic [3:0] tx_sub_q, tx_bit_q;
  logic [8:0] tx_sh_q;
  logic [3:0] rx_sub_q, rx_bit_q;
  logic rx_busy_q;
  logic [8:0] rx_sh_q;
  logic [7:0] brk_cnt_q;
  logic m0_busy_q, m0_rx_q, m0_clk_q;
  logic [3:0] m0_cnt_q, m0_bit_q;
  logic [7:0] m0_sh_q;
  logic wr_data, set_ti, set_ri, set_fe, set_br, rb8_val;
  logic [7:0] rx_byte;

  assign mode = ctrl_q[euart_pkg::C_SM0:euart_pkg::C_SM1];
  assign wr_data = wr && addr == euart_pkg::ADDR_DATA;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Divisor generator on the CPU clock; Timer 2 has no path in here.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brg_cnt_q <= euart_pkg::DIV_RESET;
    end else if (brg_tick) begin
      brg_cnt_q <= euart_pkg::DIV_RESET; // see R10 see R12
    end else begin
      brg_cnt_q <= brg_cnt_q + 16'h0001;
    end
  end
  assign brg_tick = brg_cnt_q >= {div_hi_q, div_lo_q};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t1_half_q <= 1'b0;
    end else if (t1_ovf) begin
      t1_half_q <= ~t1_half_q;
    end
  end
  // A pulse per oversample period; zero-divisor runs at full clock.
  always_comb begin
    if (stat_q[euart_pkg::S_BRG_SEL]) begin
      var_tick = brg_tick; // see R5 see R9
    end else if (pwr_q[euart_pkg::P_HALF]) begin
      var_tick = t1_ovf;
    end else begin
      var_tick = t1_ovf && t1_half_q; // see R11
    end
  end

  // Fixed rate: divide by 2 gives CPU/32 per bit, by 1 gives CPU/16.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fix_cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      fix_cnt_q <= fix_cnt_q + 5'h01;
      if (mode == 2'b10) begin
        tick_q <= pwr_q[euart_pkg::P_HALF] || fix_cnt_q[0]; // see R8
      end else begin
        tick_q <= var_tick;
      end
    end
  end

  // Transmitter for the three framed modes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_st_q <= euart_pkg::TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1ff;
      txd <= 1'b1;
      txbuf_full_q <= 1'b0;
      txbuf_q <= 8'h00;
      tb8_buf_q <= 1'b0;
    end else begin
      case (tx_st_q)
        euart_pkg::TX_IDLE: begin
          txd <= mode == 2'b00 ? m0_clk_q : 1'b1;
          if (txbuf_full_q && tick_q) begin
            tx_sh_q <= {tb8_buf_q, txbuf_q}; // see R6
            txbuf_full_q <= 1'b0; // see R17
            tx_st_q <= euart_pkg::TX_START;
            tx_sub_q <= 4'h0;
            txd <= 1'b0; // see R3
          end
        end
        euart_pkg::TX_START, euart_pkg::TX_DATA: begin
          if (tick_q) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == 4'hf) begin
              if (tx_st_q == euart_pkg::TX_START) begin
                tx_st_q <= euart_pkg::TX_DATA;
                tx_bit_q <= 4'h0;
                txd <= tx_sh_q[0];
              end else if (tx_bit_q == (mode == 2'b01 ? 4'h7 : 4'h8)) begin
                tx_st_q <= euart_pkg::TX_STOP;
                txd <= 1'b1;
              end else begin
                tx_bit_q <= tx_bit_q + 4'h1;
                tx_sh_q <= {1'b1, tx_sh_q[8:1]};
                txd <= tx_sh_q[1];
              end
            end
          end
        end
        euart_pkg::TX_STOP: begin
          if (tick_q) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == 4'hf) begin
              tx_st_q <= euart_pkg::TX_IDLE;
            end
          end
        end
        default: tx_st_q <= euart_pkg::TX_IDLE;
      endcase
      // After the state machine, so a write in the cycle the buffer drains is not lost.
      if (wr_data && mode != 2'b00) begin
        txbuf_q <= wdata;
        tb8_buf_q <= ctrl_q[euart_pkg::C_TB8]; // see R21
        txbuf_full_q <= 1'b1;
      end
      if (mode == 2'b00 && tx_st_q == euart_pkg::TX_IDLE) begin
        txd <= m0_clk_q; // see R1
      end
    end
  end

  // Shift-register mode: clock low half then high, data changes one clock after the fall.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m0_busy_q <= 1'b0;
      m0_rx_q <= 1'b0;
      m0_clk_q <= 1'b1;
      m0_cnt_q <= 4'h0;
      m0_bit_q <= 4'h0;
      m0_sh_q <= 8'h00;
      rxd_out <= 1'b1;
      rxd_oen <= 1'b1;
    end else if (!m0_busy_q) begin
      m0_clk_q <= 1'b1;
      rxd_oen <= 1'b1;
      if (mode == 2'b00 && (wr_data || (wr && addr == euart_pkg::ADDR_CTRL &&
          wdata[euart_pkg::C_REN] && !wdata[euart_pkg::C_RI]))) begin
        m0_busy_q <= 1'b1;
        // Falling here gives the first bit a full eight-clock low phase.
        m0_clk_q <= 1'b0;
        m0_rx_q <= !wr_data;
        m0_sh_q <= wdata;
        m0_cnt_q <= 4'h0;
        m0_bit_q <= 4'h0;
      end
    end else begin
      m0_cnt_q <= m0_cnt_q + 4'h1; // see R2
      rxd_oen <= m0_rx_q;
      rxd_out <= m0_sh_q[0];
      if (m0_cnt_q == 4'h7) begin
        m0_clk_q <= 1'b1;
        if (m0_rx_q) begin
          m0_sh_q <= {rx_s2_q, m0_sh_q[7:1]}; // see R1
        end
      end else if (m0_cnt_q == 4'hf) begin
        // No fall after the last bit, or the idle clock would glitch low for a cycle.
        m0_clk_q <= m0_bit_q == 4'h7;
        if (!m0_rx_q) begin
          m0_sh_q <= {1'b1, m0_sh_q[7:1]};
        end
        m0_bit_q <= m0_bit_q + 4'h1;
        if (m0_bit_q == 4'h7) begin
          m0_busy_q <= 1'b0;
        end
      end else if (m0_cnt_q == 4'h0) begin
        m0_clk_q <= 1'b0;
      end
    end
  end

  // Framed receiver, oversampled sixteen times per bit.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_busy_q <= 1'b0;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end else if (mode == 2'b00 || !ctrl_q[euart_pkg::C_REN]) begin
      rx_busy_q <= 1'b0;
    end else if (tick_q) begin
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1; // see R22
          rx_sub_q <= 4'h1;
          rx_bit_q <= 4'h0;
        end
      end else begin
        rx_sub_q <= rx_sub_q + 4'h1;
        if (rx_sub_q == euart_pkg::SAMPLE_MID) begin
          if (rx_bit_q == 4'h0 && rx_s2_q) begin
            rx_busy_q <= 1'b0;
          end else if (rx_bit_q == (mode == 2'b01 ? 4'h9 : 4'ha)) begin
            rx_busy_q <= 1'b0;
          end else if (rx_bit_q != 4'h0) begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
          end
          rx_bit_q <= rx_bit_q + 4'h1;
        end
      end
    end
  end
  assign set_fe = tick_q && rx_busy_q && rx_sub_q == euart_pkg::SAMPLE_MID &&
                  rx_bit_q == (mode == 2'b01 ? 4'h9 : 4'ha) && !rx_s2_q; // see R23
  assign set_ri = (tick_q && rx_busy_q && rx_sub_q == euart_pkg::SAMPLE_MID &&
                   rx_bit_q == (mode == 2'b01 ? 4'h9 : 4'ha)) ||
                  (m0_busy_q && m0_rx_q && m0_cnt_q == 4'hf && m0_bit_q == 4'h7);
  // Mode 1 keeps the stop bit, the 9-bit modes keep the ninth bit.
  assign rb8_val = mode == 2'b01 ? rx_s2_q : rx_sh_q[8]; // see R4 see R7
  assign rx_byte = mode == 2'b00 ? m0_sh_q :
                   (mode == 2'b01 ? rx_sh_q[8:1] : rx_sh_q[7:0]);

  // Break counter in oversample ticks, eleven bits of sixteen each.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brk_cnt_q <= 8'h00;
    end else if (rx_s2_q) begin
      brk_cnt_q <= 8'h00;
    end else if (tick_q && brk_cnt_q != 8'(euart_pkg::BREAK_BITS * euart_pkg::OVERSAMPLE)) begin
      brk_cnt_q <= brk_cnt_q + 8'h01;
    end
  end
  assign set_br = tick_q && !rx_s2_q &&
                  brk_cnt_q == 8'(euart_pkg::BREAK_BITS * euart_pkg::OVERSAMPLE - 1); // see R15

  // Transmit flag: buffer drained with double buffering, else frame end.
  assign set_ti = stat_q[euart_pkg::S_DBM] ?
                  (txbuf_full_q && tick_q && tx_st_q == euart_pkg::TX_IDLE) : // see R20
                  ((tx_st_q == euart_pkg::TX_STOP && tick_q && tx_sub_q == 4'hf) ||
                   (m0_busy_q && !m0_rx_q && m0_cnt_q == 4'hf && m0_bit_q == 4'h7)); // see R18

  // Registers; hardware sets win over software clears.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= euart_pkg::CTRL_RESET;
      stat_q <= euart_pkg::STAT_RESET;
      pwr_q <= 8'h00;
      div_lo_q <= 8'h00;
      div_hi_q <= 8'h00;
      rxbuf_q <= 8'h00;
      break_reset_req <= 1'b0;
    end else begin
      if (wr && addr == euart_pkg::ADDR_CTRL) begin
        // Bit 7 write is dropped while error view is set.
        ctrl_q <= {pwr_q[euart_pkg::P_VIEW] ? ctrl_q[7] : wdata[7], wdata[6:0]}; // see R14
        if (pwr_q[euart_pkg::P_VIEW] && !wdata[7]) begin
          stat_q[euart_pkg::S_FE] <= 1'b0;
        end
      end
      if (wr && addr == euart_pkg::ADDR_STAT) begin
        stat_q <= {wdata[7:5], 1'b0, wdata[3:2] & stat_q[3:2], 2'b00};
      end
      if (wr && addr == euart_pkg::ADDR_PWR) begin
        pwr_q <= wdata;
      end
      if (wr && addr == euart_pkg::ADDR_DIVL) begin
        div_lo_q <= wdata;
      end
      if (wr && addr == euart_pkg::ADDR_DIVH) begin
        div_hi_q <= wdata;
      end
      if (set_ti) begin
        ctrl_q[euart_pkg::C_TI] <= 1'b1;
      end
      if (set_ri) begin
        ctrl_q[euart_pkg::C_RI] <= 1'b1;
        ctrl_q[euart_pkg::C_RB8] <= rb8_val;
        rxbuf_q <= rx_byte;
      end
      if (set_fe) begin
        stat_q[euart_pkg::S_FE] <= 1'b1; // see R13
      end
      if (set_br) begin
        stat_q[euart_pkg::S_BR] <= 1'b1;
      end
      break_reset_req <= set_br && stat_q[euart_pkg::S_BRK_RST]; // see R16
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        euart_pkg::ADDR_CTRL: rdata <= {pwr_q[euart_pkg::P_VIEW] ?
                                        stat_q[euart_pkg::S_FE] : ctrl_q[7], ctrl_q[6:0]};
        euart_pkg::ADDR_DATA: rdata <= rxbuf_q;
        euart_pkg::ADDR_STAT: rdata <= {stat_q[7:2], txbuf_full_q, rx_busy_q};
        euart_pkg::ADDR_PWR: rdata <= pwr_q;
        euart_pkg::ADDR_DIVL: rdata <= div_lo_q;
        euart_pkg::ADDR_DIVH: rdata <= div_hi_q;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

/* File: sim/euart_props.sv */
// Purpose: Port-level checks for the enhanced serial port.
// Assumes: Mode 0 shift clock is low 8 clocks, then high 8 clocks.
// Notes: A tick comes at most once a clock, so low runs give lower bounds on time.
`timescale 1ns/1ps
module euart_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Rate source and pins.
  input wire logic t1_ovf,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oen,
  input wire logic txd,
  input wire logic break_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [9:0] low_q;
  // Saturates so that a held line never wraps back to a short run.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) low_q <= 10'h000;
    else if (rxd_in) low_q <= 10'h000;
    else if (low_q != 10'h3ff) low_q <= low_q + 10'h001;
  end
  sequence s_clk_low;
    !txd [*8];
  endsequence
  sequence s_clk_high;
    txd [*8];
  endsequence
  property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
  property p_unmapped; rd && addr > euart_pkg::ADDR_DIVH |=> rdata == 8'h00; endproperty
  property p_brk_pulse; break_reset_req |=> !break_reset_req; endproperty
  property p_brk_cause; break_reset_req |-> $past(low_q, 3) >= 10'h0aa; endproperty
  property p_shift_clk; $fell(txd) && !rxd_oen |-> s_clk_low ##1 s_clk_high; endproperty
  property p_start_min; $fell(txd) && rxd_oen |-> s_clk_low; endproperty
  property p_release; $rose(rxd_oen) |-> txd; endproperty
  property p_data_hold;
    !rxd_oen && !$past(rxd_oen) && !txd && !$past(txd) |-> $stable(rxd_out);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_brk_pulse: assert property (p_brk_pulse) else $error("reset request too long");
  a_brk_cause: assert property (p_brk_cause) else $error("break too early");
  a_shift_clk: assert property (p_shift_clk) else $error("shift clock shape");
  a_start_min: assert property (p_start_min) else $error("start bit short");
  a_release: assert property (p_release) else $error("release with clock low");
  a_data_hold: assert property (p_data_hold) else $error("data moved");
endmodule

/* File: sim/serial_peer.sv */
// Purpose: Remote serial device driving the receive line.
// Assumes: Bit times are whole numbers of clocks.
// Notes: The line idles high, as if pulled up.
`timescale 1ns/1ps
module serial_peer (
  // Clock.
  input wire logic clk,
  // Shift clock from the port in shift-register mode.
  input wire logic sclk,
  // Line toward the port.
  output logic line
);
  initial line = 1'b1;
  // Frames go out start bit first, data LSB first.
  task automatic send(input logic [11:0] f, input int n, input int bl);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      line <= f[i];
      repeat (bl - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
  endtask
  // Shift-register peripheral: next bit after each rising shift clock.
  task automatic shift_out(input logic [7:0] b);
    line <= b[0];
    for (int i = 1; i < 9; i++) begin
      for (int k = 0; k < 40 && sclk; k++) @(posedge clk);
      for (int k = 0; k < 40 && !sclk; k++) @(posedge clk);
      line <= i < 8 ? b[i] : 1'b1;
    end
  endtask
  task automatic hold_low(input int n);
    @(posedge clk);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule

/* File: sim/enhanced_uart_with_brg_test.sv */
// Purpose: Self-checking bench for the enhanced serial port.
// Assumes: Divisor 0 gives one tick a clock, so a bit is 16 clocks.
// Notes: Timer 1 overflow pulses every second clock for the whole run.
`timescale 1ns/1ps
module enhanced_uart_with_brg_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic t1_ovf = 1'b0;
  logic [7:0] rdata, d;
  logic rxd_out, rxd_oen, txd, break_reset_req, peer_line, rxd_line;
  logic [21:0] v;
  int failures = 0;
  int compares = 0;
  always #5 clk = ~clk;
  always @(posedge clk) t1_ovf <= !t1_ovf;
  // The port drives the receive pin only in shift mode.
  assign rxd_line = !rxd_oen ? rxd_out : peer_line;
  euart dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .t1_ovf(t1_ovf), .rxd_in(rxd_line), .rxd_out(rxd_out),
    .rxd_oen(rxd_oen), .txd(txd), .break_reset_req(break_reset_req));
  serial_peer peer_u (.clk(clk), .sclk(txd), .line(peer_line));
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h, want %h", $time, (a), (e)); end end
  task automatic stop_test;
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_txd(input logic lv, inout int k);
    while (txd !== lv && k < 4000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000) begin
      failures++;
      stop_test();
    end
  endtask
  // Samples n bits of bl clocks each near their centres.
  task automatic get_tx(input int n, input int bl, output logic [21:0] q);
    int k;
    k = 0;
    q = '0;
    wait_txd(1'b0, k);
    repeat (bl / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      q[i] = txd;
      repeat (bl) @(negedge clk);
    end
  endtask
  task automatic t_mode1;
    wreg(euart_pkg::ADDR_STAT, 8'h20);
    wreg(euart_pkg::ADDR_DIVL, 8'h01);
    wreg(euart_pkg::ADDR_CTRL, 8'h40);
    fork get_tx(10, 32, v); join_none
    wreg(euart_pkg::ADDR_DATA, 8'hA5);
    repeat (40) @(posedge clk);
    rreg(euart_pkg::ADDR_CTRL);
    `CHK(d[1], 1'b0)
    wait fork;
    `CHK(v[9:0], {1'b1, 8'hA5, 1'b0})
    rreg(euart_pkg::ADDR_CTRL);
    `CHK(d[1], 1'b1)
  endtask
  task automatic t_dbuf;
    wreg(euart_pkg::ADDR_DIVL, 8'h00);
    wreg(euart_pkg::ADDR_STAT, 8'hA0);
    wreg(euart_pkg::ADDR_CTRL, 8'h40);
    fork get_tx(20, 16, v); join_none
    wreg(euart_pkg::ADDR_DATA, 8'h11);
    wreg(euart_pkg::ADDR_DATA, 8'h22);
    rreg(euart_pkg::ADDR_CTRL);
    `CHK(d[1], 1'b1)
    wait fork;
    `CHK(v[19:0], {1'b1, 8'h22, 2'b01, 8'h11, 1'b0})
  endtask
  // Fixed 9-bit mode at both rates, then variable 9-bit mode on Timer 1.
  task automatic t_nine;
    for (int i = 0; i < 4; i++) begin
      wreg(euart_pkg::ADDR_STAT, 8'h80);
      wreg(euart_pkg::ADDR_PWR, {~i[0], 7'h00});
      wreg(euart_pkg::ADDR_CTRL, i[1] ? 8'hC8 : 8'h88);
      fork get_tx(11, 16 << (i - i[1]), v); join_none
      wreg(euart_pkg::ADDR_DATA, 8'h5C);
      wreg(euart_pkg::ADDR_CTRL, i[1] ? 8'hC0 : 8'h80);
      wait fork;
      `CHK(v[10:0], {2'b11, 8'h5C, 1'b0})
    end
  endtask
  task automatic t_rx;
    wreg(euart_pkg::ADDR_STAT, 8'h20);
    wreg(euart_pkg::ADDR_PWR, 8'h00);
    wreg(euart_pkg::ADDR_CTRL, 8'h50);
    peer_u.send({1'b1, 8'h3C, 1'b0}, 10, 16);
    repeat (4) @(posedge clk);
    rreg(euart_pkg::ADDR_CTRL);
    `CHK(d, 8'h55)
    rreg(euart_pkg::ADDR_DATA);
    `CHK(d, 8'h3C)
    wreg(euart_pkg::ADDR_CTRL, 8'hD0);
    peer_u.send({2'b10, 8'hC3, 1'b0}, 11, 16);
    repeat (4) @(posedge clk);
    rreg(euart_pkg::ADDR_CTRL);
    `CHK(d, 8'hD1)
    wreg(euart_pkg::ADDR_CTRL, 8'hD0);
    peer_u.send({2'b01, 8'h5A, 1'b0}, 11, 16);
    wreg(euart_pkg::ADDR_PWR, 8'h40);
    rreg(euart_pkg::ADDR_CTRL);
    `CHK(d[7], 1'b1)
    rreg(euart_pkg::ADDR_STAT);
    `CHK(d[2], 1'b1)
    wreg(euart_pkg::ADDR_PWR, 8'h00);
    wreg(euart_pkg::ADDR_STAT, 8'h20);
    rreg(euart_pkg::ADDR_STAT);
    `CHK(d[2], 1'b0)
  endtask
  task automatic t_break;
    int k;
    k = 0;
    wreg(euart_pkg::ADDR_STAT, 8'h60);
    fork peer_u.hold_low(300); join_none
    while (break_reset_req !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    `CHK(k < 400, 1'b1)
    `CHK(k > 170, 1'b1)
    wait fork;
    rreg(euart_pkg::ADDR_STAT);
    `CHK(d[3], 1'b1)
  endtask
  task automatic t_mode0;
    int k;
    k = 0;
    wreg(euart_pkg::ADDR_STAT, 8'h00);
    wreg(euart_pkg::ADDR_CTRL, 8'h00);
    wreg(euart_pkg::ADDR_DATA, 8'h96);
    for (int i = 0; i < 8; i++) begin
      wait_txd(1'b0, k);
      wait_txd(1'b1, k);
      v[i] = rxd_out;
    end
    `CHK(v[7:0], 8'h96)
    `CHK(k >= 120 && k < 150, 1'b1)
    repeat (16) @(posedge clk);
    fork peer_u.shift_out(8'h4B); join_none
    wreg(euart_pkg::ADDR_CTRL, 8'h10);
    wait fork;
    repeat (16) @(posedge clk);
    rreg(euart_pkg::ADDR_DATA);
    `CHK(d, 8'h4B)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rreg(euart_pkg::ADDR_STAT);
    `CHK(d, euart_pkg::STAT_RESET)
    rreg(3'h7);
    `CHK(d, 8'h00)
    t_mode1();
    t_dbuf();
    t_nine();
    t_rx();
    t_break();
    t_mode0();
    stop_test();
  end
endmodule
bind euart euart_props props_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .t1_ovf(t1_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
  .rxd_oen(rxd_oen), .txd(txd), .break_reset_req(break_reset_req));
